// ---- logic/csd_pkg.sv ----
/*
  Constants and types shared by the CAN node setting decoder.
  Assumes each selector level arrives as a millivolt reading from an on-chip converter.
*/
package csd_pkg;

  // Selector readings are in millivolts, wide enough for the 0 to 3 V range.
  localparam int unsigned MV_W = 12;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned RATE_W = 10;
  localparam int unsigned NUM_SEL = 3;

  // Channel order in the selector interface.
  localparam int unsigned CH_ID_LOW = 0;
  localparam int unsigned CH_ID_HIGH = 1;
  localparam int unsigned CH_RATE = 2;

  // Quantiser steps and tolerances in millivolts.
  localparam logic [MV_W-1:0] ADDR_STEP_MV = 12'h0c8;
  localparam logic [MV_W-1:0] ADDR_TOL_MV = 12'h064;
  localparam logic [MV_W-1:0] RATE_STEP_MV = 12'h3e8;
  localparam logic [MV_W-1:0] RATE_TOL_MV = 12'h184;
  localparam logic [CODE_W-1:0] ADDR_CODE_MAX = 4'hf;
  localparam logic [CODE_W-1:0] RATE_CODE_MAX = 4'h3;

  // Field positions of the node identifier.
  localparam int unsigned ID_LOW_LSB = 0;
  localparam int unsigned ID_HIGH_LSB = 4;

  // Node identifier decode limits.
  localparam logic [7:0] NODE_ID_FROM_MEM = 8'h00;
  localparam logic [7:0] NODE_ID_MAX = 8'h7f;

  // Bit rate codes and rates in kbit/s.
  localparam logic [1:0] RATE_CODE_MEM = 2'h0;
  localparam logic [1:0] RATE_CODE_500K = 2'h1;
  localparam logic [1:0] RATE_CODE_250K = 2'h2;
  localparam logic [1:0] RATE_CODE_125K = 2'h3;
  localparam logic [RATE_W-1:0] RATE_500K = 10'h1f4;
  localparam logic [RATE_W-1:0] RATE_250K = 10'h0fa;
  localparam logic [RATE_W-1:0] RATE_125K = 10'h07d;

  // Values shown before the decode completes.
  localparam logic [7:0] NODE_ID_RESET = 8'h00;
  localparam logic [RATE_W-1:0] RATE_RESET = 10'h000;

  // Settling time for the converter after reset, in ns, and its cycle count at 20 MHz.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SETTLE_NS = 200;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 4;

  typedef enum {
    ST_SETTLE,
    ST_CAPTURE,
    ST_DONE
  } csd_state_t;

endpackage

// ---- logic/csd_sel_if.sv ----
/*
  Carrier between the decoder top and its selector quantisers.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface csd_sel_if;
  import csd_pkg::*;

  logic [MV_W-1:0] mv [NUM_SEL];
  logic [CODE_W-1:0] code [NUM_SEL];
  logic in_tol [NUM_SEL];

  modport top (output mv, input code, input in_tol);
  modport quant (input mv, output code, output in_tol);
endinterface

// ---- logic/csd_quantizer.sv ----
/*
  Rounds one millivolt reading to the nearest step and flags readings off the step.
  Assumes the reading is stable for at least two cycles before it is used.
*/
`timescale 1ns/1ps
module csd_quantizer
  import csd_pkg::*;
#(
  parameter logic [MV_W-1:0] STEP_MV = ADDR_STEP_MV,
  parameter logic [MV_W-1:0] TOL_MV = ADDR_TOL_MV,
  parameter logic [CODE_W-1:0] CODE_MAX = ADDR_CODE_MAX,
  parameter int unsigned CH = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  csd_sel_if.quant sel
);

  logic [CODE_W-1:0] code_r;
  logic [CODE_W-1:0] code_nxt;
  logic tol_r;
  logic tol_nxt;

  always_comb begin
    logic [MV_W:0] rounded;
    logic [MV_W:0] nominal;
    logic [MV_W:0] dev;
    nominal = '0;
    dev = '0;
    rounded = ({1'b0, sel.mv[CH]} + {2'b00, STEP_MV[MV_W-1:1]}) / {1'b0, STEP_MV};
    // Readings beyond full scale clamp to the top code; tolerance is then judged against the top step's level.
    if (rounded > {{(MV_W+1-CODE_W){1'b0}}, CODE_MAX}) begin
      rounded = {{(MV_W+1-CODE_W){1'b0}}, CODE_MAX};
    end
    nominal = (MV_W+1)'(rounded * {1'b0, STEP_MV});
    dev = ({1'b0, sel.mv[CH]} > nominal) ? ({1'b0, sel.mv[CH]} - nominal)
                                         : (nominal - {1'b0, sel.mv[CH]});
    code_nxt = rounded[CODE_W-1:0];
    tol_nxt = (dev <= {1'b0, TOL_MV});
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_r <= '0;
      tol_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      tol_r <= tol_nxt;
    end
  end

  assign sel.code[CH] = code_r;
  assign sel.in_tol[CH] = tol_r;

endmodule // csd_quantizer

// ---- logic/csd_decoder.sv ----
/*
  CAN node setting decoder: turns the strapped selector levels into a node identifier
  and a bit rate once after reset, falling back to non-volatile values where asked.
  Assumes the selector levels are static straps and the stored values are valid at reset.
*/
// How it works
// RQ1 - Low address selector code forms node identifier bits 3 to 0.
// RQ2 - High address selector code forms node identifier bits 7 to 4.
// RQ3 - Address levels sit on 0.2 V steps, 0 to 3 V, giving codes 0-15.
// RQ4 - Combined code zero takes the node identifier from non-volatile memory.
// RQ5 - Codes 1 to 127 are used directly; 128 and above use memory.
// RQ6 - Bit rate level is whole volts 0 to 3, within 0.388 V, 2-bit code.
// RQ7 - Codes 1, 2, 3 select 500, 250 and 125 kbit/s.
// RQ8 - Bit rate code zero uses the stored rate, which may be any rate.
// RQ9 - Sample once after reset release and hold results until the next reset.
`timescale 1ns/1ps
module csd_decoder
  import csd_pkg::*;
(
  // Clock and reset.
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  // Selector readings in millivolts.
  input wire logic [MV_W-1:0] NODE_ID_LOW_SELECTOR_MV_IN,
  input wire logic [MV_W-1:0] NODE_ID_HIGH_SELECTOR_MV_IN,
  input wire logic [MV_W-1:0] BIT_RATE_SELECTOR_MV_IN,
  // Values held in non-volatile memory.
  input wire logic [7:0] MEM_NODE_ID_IN,
  input wire logic [RATE_W-1:0] MEM_BIT_RATE_KBPS_IN,
  // Settings handed to the CAN controller.
  output logic [7:0] NODE_ID_OUT,
  output logic [RATE_W-1:0] BIT_RATE_KBPS_OUT,
  output logic SETTINGS_VALID_OUT,
  output logic NODE_ID_FROM_MEM_OUT,
  output logic BIT_RATE_FROM_MEM_OUT,
  output logic SELECTOR_FAULT_OUT
);

  csd_sel_if sel ();

  csd_state_t state_r;
  csd_state_t state_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic [SETTLE_W-1:0] settle_nxt;
  logic [7:0] node_id_r;
  logic [7:0] node_id_nxt;
  logic [RATE_W-1:0] rate_r;
  logic [RATE_W-1:0] rate_nxt;
  logic valid_r;
  logic valid_nxt;
  logic id_mem_r;
  logic id_mem_nxt;
  logic rate_mem_r;
  logic rate_mem_nxt;
  logic fault_r;
  logic fault_nxt;

  // Maps the two-bit rate code to kbit/s; code zero defers to the stored rate.
  function automatic logic [RATE_W-1:0] rate_of(input logic [1:0] code,
                                                input logic [RATE_W-1:0] mem_rate);
    logic [RATE_W-1:0] r;
    r = mem_rate;
    unique case (code)
      RATE_CODE_MEM: r = mem_rate; // see RQ8
      RATE_CODE_500K: r = RATE_500K; // see RQ7
      RATE_CODE_250K: r = RATE_250K; // see RQ7
      RATE_CODE_125K: r = RATE_125K; // see RQ7
    endcase
    return r;
  endfunction

  assign sel.mv[CH_ID_LOW] = NODE_ID_LOW_SELECTOR_MV_IN;
  assign sel.mv[CH_ID_HIGH] = NODE_ID_HIGH_SELECTOR_MV_IN;
  assign sel.mv[CH_RATE] = BIT_RATE_SELECTOR_MV_IN;

  // The two address channels share one step; the rate channel uses whole volts.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_SEL; ch++) begin : g_quant
      csd_quantizer #(
        .STEP_MV((ch == CH_RATE) ? RATE_STEP_MV : ADDR_STEP_MV), // see RQ3, RQ6
        .TOL_MV((ch == CH_RATE) ? RATE_TOL_MV : ADDR_TOL_MV), // see RQ6
        .CODE_MAX((ch == CH_RATE) ? RATE_CODE_MAX : ADDR_CODE_MAX), // see RQ3
        .CH(ch)
      ) u_quant (
        .clk(CLOCK_IN),
        .rst_n(RESETN_IN),
        .sel(sel)
      );
    end
  endgenerate

  always_comb begin
    logic [7:0] combined;
    logic [1:0] rate_code;
    combined = '0;
    combined[ID_LOW_LSB +: CODE_W] = sel.code[CH_ID_LOW]; // see RQ1
    combined[ID_HIGH_LSB +: CODE_W] = sel.code[CH_ID_HIGH]; // see RQ2
    rate_code = sel.code[CH_RATE][1:0];
    state_nxt = state_r;
    settle_nxt = settle_r;
    node_id_nxt = node_id_r;
    rate_nxt = rate_r;
    valid_nxt = valid_r;
    id_mem_nxt = id_mem_r;
    rate_mem_nxt = rate_mem_r;
    fault_nxt = fault_r;
    unique case (state_r)
      ST_SETTLE: begin
        // Waiting lets the converter and the quantiser registers fill after reset.
        if (settle_r == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          state_nxt = ST_CAPTURE;
        end else begin
          settle_nxt = settle_r + 1'b1;
        end
      end
      ST_CAPTURE: begin
        if (combined == NODE_ID_FROM_MEM || combined > NODE_ID_MAX) begin // see RQ4, RQ5
          node_id_nxt = MEM_NODE_ID_IN;
          id_mem_nxt = 1'b1;
        end else begin
          node_id_nxt = combined; // see RQ5
          id_mem_nxt = 1'b0;
        end
        // A rate level outside tolerance is not trusted, so the stored rate is used.
        if (!sel.in_tol[CH_RATE]) begin // see RQ6
          rate_nxt = MEM_BIT_RATE_KBPS_IN;
          rate_mem_nxt = 1'b1;
        end else begin
          rate_nxt = rate_of(rate_code, MEM_BIT_RATE_KBPS_IN);
          rate_mem_nxt = (rate_code == RATE_CODE_MEM); // see RQ8
        end
        fault_nxt = !sel.in_tol[CH_RATE] || !sel.in_tol[CH_ID_LOW] || !sel.in_tol[CH_ID_HIGH];
        valid_nxt = 1'b1;
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        state_nxt = ST_DONE; // see RQ9
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      state_r <= ST_SETTLE;
      settle_r <= '0;
      node_id_r <= NODE_ID_RESET;
      rate_r <= RATE_RESET;
      valid_r <= 1'b0;
      id_mem_r <= 1'b0;
      rate_mem_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      node_id_r <= node_id_nxt;
      rate_r <= rate_nxt;
      valid_r <= valid_nxt;
      id_mem_r <= id_mem_nxt;
      rate_mem_r <= rate_mem_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign NODE_ID_OUT = node_id_r;
  assign BIT_RATE_KBPS_OUT = rate_r;
  assign SETTINGS_VALID_OUT = valid_r;
  assign NODE_ID_FROM_MEM_OUT = id_mem_r;
  assign BIT_RATE_FROM_MEM_OUT = rate_mem_r;
  assign SELECTOR_FAULT_OUT = fault_r;

endmodule // csd_decoder

// ---- bench/csd_strap_model.sv ----
/* Host board strap model: turns chosen selector codes into applied millivolt levels.
   Assumes the bench keeps the codes static while a decode runs. */
`timescale 1ns/1ps
module csd_strap_model
  import csd_pkg::*;
(
  // Chosen straps.
  input wire logic [3:0] lo_code_in,
  input wire logic [3:0] hi_code_in,
  input wire logic [1:0] rate_code_in,
  input wire logic signed [11:0] rate_off_in,
  // Levels at the decoder.
  output logic [MV_W-1:0] lo_mv_out,
  output logic [MV_W-1:0] hi_mv_out,
  output logic [MV_W-1:0] rate_mv_out
);
  // Address straps sit exactly on their step.
  assign lo_mv_out = MV_W'(lo_code_in * ADDR_STEP_MV);
  assign hi_mv_out = MV_W'(hi_code_in * ADDR_STEP_MV);
  // The offset lets a board sit at the edge of the rate tolerance.
  assign rate_mv_out = MV_W'(int'(rate_code_in) * 32'sh3e8 + int'(rate_off_in));
endmodule // csd_strap_model

// ---- bench/csd_decoder_chk.sv ----
/* Checker for the decoded settings against the strapped levels.
   Assumes the straps stay static from reset release until the settings are valid. */
`timescale 1ns/1ps
module csd_decoder_chk
  import csd_pkg::*;
(
  // Decoder ports.
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic [MV_W-1:0] NODE_ID_LOW_SELECTOR_MV_IN,
  input wire logic [MV_W-1:0] NODE_ID_HIGH_SELECTOR_MV_IN,
  input wire logic [MV_W-1:0] BIT_RATE_SELECTOR_MV_IN,
  input wire logic [7:0] MEM_NODE_ID_IN,
  input wire logic [RATE_W-1:0] MEM_BIT_RATE_KBPS_IN,
  input wire logic [7:0] NODE_ID_OUT,
  input wire logic [RATE_W-1:0] BIT_RATE_KBPS_OUT,
  input wire logic SETTINGS_VALID_OUT,
  input wire logic NODE_ID_FROM_MEM_OUT,
  input wire logic BIT_RATE_FROM_MEM_OUT,
  input wire logic SELECTOR_FAULT_OUT
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  int lo_c;
  int hi_c;
  int rc;
  int rdev;
  logic [7:0] cid;
  logic [RATE_W-1:0] rexp;
  always_comb begin
    cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
    if (!RESETN_IN) begin
      cnt_nxt = 3'h0;
    end
    lo_c = (int'(NODE_ID_LOW_SELECTOR_MV_IN) + 32'sh64) / 32'shc8;
    hi_c = (int'(NODE_ID_HIGH_SELECTOR_MV_IN) + 32'sh64) / 32'shc8;
    rc = (int'(BIT_RATE_SELECTOR_MV_IN) + 32'sh1f4) / 32'sh3e8;
    lo_c = (lo_c > 32'shf) ? 32'shf : lo_c;
    hi_c = (hi_c > 32'shf) ? 32'shf : hi_c;
    rc = (rc > 32'sh3) ? 32'sh3 : rc;
    rdev = int'(BIT_RATE_SELECTOR_MV_IN) - rc * 32'sh3e8;
    rdev = (rdev < 32'sh0) ? -rdev : rdev;
    cid = {hi_c[3:0], lo_c[3:0]};
    rexp = (rc == 32'sh1) ? RATE_500K : (rc == 32'sh2) ? RATE_250K : RATE_125K;
  end
  always_ff @(posedge CLOCK_IN) begin
    cnt_r <= cnt_nxt;
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_done;
    $rose(SETTINGS_VALID_OUT);
  endsequence
  chk_valid_time: assert property (SETTINGS_VALID_OUT == (cnt_r >= 3'h5))
    else $error("valid flag timing wrong");
  chk_hold_out: assert property (SETTINGS_VALID_OUT && $past(SETTINGS_VALID_OUT) |->
    $stable(NODE_ID_OUT) && $stable(BIT_RATE_KBPS_OUT) && $stable(SELECTOR_FAULT_OUT) &&
    $stable(NODE_ID_FROM_MEM_OUT) && $stable(BIT_RATE_FROM_MEM_OUT))
    else $error("settings moved after capture");
  chk_zero_early: assert property (!SETTINGS_VALID_OUT |->
    NODE_ID_OUT == NODE_ID_RESET && BIT_RATE_KBPS_OUT == RATE_RESET)
    else $error("settings shown before decode");
  chk_id_direct: assert property (s_done ##0
    (cid != 8'h00 && cid <= NODE_ID_MAX) |-> NODE_ID_OUT == cid && !NODE_ID_FROM_MEM_OUT)
    else $error("node id not from selectors");
  chk_id_mem: assert property (s_done ##0
    (cid == NODE_ID_FROM_MEM || cid > NODE_ID_MAX) |->
    NODE_ID_OUT == MEM_NODE_ID_IN && NODE_ID_FROM_MEM_OUT) else $error("node id not stored");
  chk_rate_table: assert property (s_done ##0
    (rc != 32'sh0 && rdev <= 32'sh184) |-> BIT_RATE_KBPS_OUT == rexp && !BIT_RATE_FROM_MEM_OUT)
    else $error("bit rate wrong");
  chk_rate_mem: assert property (s_done ##0 (rc == 32'sh0) |->
    BIT_RATE_KBPS_OUT == MEM_BIT_RATE_KBPS_IN && BIT_RATE_FROM_MEM_OUT)
    else $error("rate not stored");
  chk_rate_fault: assert property (s_done ##0 (rdev > 32'sh184) |->
    SELECTOR_FAULT_OUT && BIT_RATE_FROM_MEM_OUT) else $error("rate level off step not flagged");
endmodule // csd_decoder_chk
bind csd_decoder csd_decoder_chk chk_u (.CLOCK_IN(CLOCK_IN), .RESETN_IN(RESETN_IN),
  .NODE_ID_LOW_SELECTOR_MV_IN(NODE_ID_LOW_SELECTOR_MV_IN),
  .NODE_ID_HIGH_SELECTOR_MV_IN(NODE_ID_HIGH_SELECTOR_MV_IN),
  .BIT_RATE_SELECTOR_MV_IN(BIT_RATE_SELECTOR_MV_IN), .MEM_NODE_ID_IN(MEM_NODE_ID_IN),
  .MEM_BIT_RATE_KBPS_IN(MEM_BIT_RATE_KBPS_IN), .NODE_ID_OUT(NODE_ID_OUT),
  .BIT_RATE_KBPS_OUT(BIT_RATE_KBPS_OUT), .SETTINGS_VALID_OUT(SETTINGS_VALID_OUT),
  .NODE_ID_FROM_MEM_OUT(NODE_ID_FROM_MEM_OUT), .BIT_RATE_FROM_MEM_OUT(BIT_RATE_FROM_MEM_OUT),
  .SELECTOR_FAULT_OUT(SELECTOR_FAULT_OUT));

// ---- bench/testbench.sv ----
/* Self-checking bench for the setting decoder: strap table, start-up timing, hold, reset.
   Assumes the strap model gives static levels for each reset. */
`timescale 1ns/1ps
module testbench;
  import csd_pkg::*;
  typedef struct packed {
    logic [3:0] lo;
    logic [3:0] hi;
    logic [1:0] rc;
    logic signed [11:0] off;
    logic [7:0] id;
    logic [RATE_W-1:0] rate;
    logic [2:0] flags;
  } csd_row_t;
  localparam logic [7:0] MEM_ID = 8'h5a;
  // A stored rate beyond the strap choices.
  localparam logic [RATE_W-1:0] MEM_RATE = 10'h3e8;
  csd_row_t rows [7] = '{
    '{4'h0, 4'h0, 2'h1, 12'sh000, MEM_ID, RATE_500K, 3'h4},
    '{4'h2, 4'h0, 2'h2, 12'sh000, 8'h02, RATE_250K, 3'h0},
    '{4'he, 4'h7, 2'h3, 12'sh000, 8'h7e, RATE_125K, 3'h0},
    '{4'hf, 4'h7, 2'h0, 12'sh000, 8'h7f, MEM_RATE, 3'h2},
    '{4'h0, 4'h8, 2'h1, 12'sh184, MEM_ID, RATE_500K, 3'h4},
    '{4'hf, 4'hf, 2'h2, -12'sh184, MEM_ID, RATE_250K, 3'h4},
    '{4'h1, 4'h0, 2'h2, 12'sh185, 8'h01, MEM_RATE, 3'h3}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] lo = 4'h0;
  logic [3:0] hi = 4'h0;
  logic [1:0] rc = 2'h0;
  logic signed [11:0] off = 12'sh000;
  logic [MV_W-1:0] lo_mv;
  logic [MV_W-1:0] hi_mv;
  logic [MV_W-1:0] rate_mv;
  logic [7:0] node_id;
  logic [RATE_W-1:0] rate;
  logic valid;
  logic id_mem;
  logic rate_mem;
  logic fault;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  csd_strap_model strap_u (.lo_code_in(lo), .hi_code_in(hi), .rate_code_in(rc),
    .rate_off_in(off), .lo_mv_out(lo_mv), .hi_mv_out(hi_mv), .rate_mv_out(rate_mv));
  csd_decoder dut_u (.CLOCK_IN(clk), .RESETN_IN(rst_n), .NODE_ID_LOW_SELECTOR_MV_IN(lo_mv),
    .NODE_ID_HIGH_SELECTOR_MV_IN(hi_mv), .BIT_RATE_SELECTOR_MV_IN(rate_mv),
    .MEM_NODE_ID_IN(MEM_ID), .MEM_BIT_RATE_KBPS_IN(MEM_RATE), .NODE_ID_OUT(node_id),
    .BIT_RATE_KBPS_OUT(rate), .SETTINGS_VALID_OUT(valid), .NODE_ID_FROM_MEM_OUT(id_mem),
    .BIT_RATE_FROM_MEM_OUT(rate_mem), .SELECTOR_FAULT_OUT(fault));
  task automatic summarize;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [RATE_W-1:0] exp,
                     input logic [RATE_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Straps change only under reset, so the capture after release sees them settled.
  task automatic start_run(input csd_row_t r);
    @(posedge clk);
    rst_n <= 1'b0;
    lo <= r.lo;
    hi <= r.hi;
    rc <= r.rc;
    off <= r.off;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cyc = 0;
    while (cyc < 20 && valid !== 1'b1) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (valid !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic check_row(input csd_row_t r);
    cmp("node id", RATE_W'(r.id), RATE_W'(node_id));
    cmp("bit rate", r.rate, rate);
    cmp("flags", RATE_W'(r.flags), RATE_W'({id_mem, rate_mem, fault}));
    cmp("start cycles", 10'h005, RATE_W'(cyc));
  endtask
  initial begin
    foreach (rows[k]) begin
      start_run(rows[k]);
      check_row(rows[k]);
    end
    // Straps moved after capture must not reach the outputs.
    @(posedge clk);
    lo <= 4'h3;
    rc <= 2'h1;
    repeat (6) @(posedge clk);
    #1;
    check_row(rows[6]);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    cmp("in reset", 10'h000, RATE_W'({valid, node_id}));
    cmp("rate in reset", RATE_RESET, rate);
    cmp("flags in reset", 10'h000, RATE_W'({id_mem, rate_mem, fault}));
    start_run(rows[2]);
    check_row(rows[2]);
    summarize();
  end
endmodule // testbench
